// [verilog/led_matrix_refresh_scanner.sv]
// Overview of operation
// (R1) Hold 20x8 pixels, drive columns in parallel
// (R2) Enable one row driver at a time
// (R3) Full pass over rows takes 512 cycles
// (R4) Each row slot lasts 64 display cycles
// (R5) Blank columns four cycles at row change
// (R6) Pulse-width code sets lit cycles per slot
// (R7) Code 1101 lights sixty percent of slot
// (R8) Peak bits 00 give 73 percent current
// (R9) Both codes from control word zero, independent
// (R10) Display clock internal or external, as configured
// (R11) Columns show data of the enabled row
// (R12) External clock should be 51.2 kHz or more
// (R13) Prescaler bit divides external clock by eight
// (R14) Sleep stops oscillator and drivers, keeps data
// (R15) D4-D5 peak current, D0-D3 pulse width
// (R16) Reset returns counters to first slot start
// (R17) Lit time follows blanking, then columns off
`include "scan_defs.svh"
`default_nettype none

module led_matrix_refresh_scanner #(
  parameter int unsigned INT_DIV = `INT_OSC_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        ext_osc,
  output var  logic [7:0]  row_en,
  output var  logic [19:0] col_on,
  output var  logic [6:0]  col_current_pct
);

  scan_pkg::ctrl_word_t ctrl0_r;
  scan_pkg::ctrl_word_t ctrl1_r;
  logic                 osc_sel_r;
  scan_pkg::col_vec_t   dot_r [8];
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;
  logic                 acc;
  logic [31:0]          rd_nxt;
  logic                 tick;
  scan_pkg::scan_cnt_t  cnt;
  logic [2:0]           row;
  logic [5:0]           cyc;
  logic                 run;
  scan_pkg::on_cyc_t    on_cyc;
  logic                 lit;
  scan_pkg::col_vec_t   row_data;

  // Bus slave: zero wait states, always OKAY
  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_r <= 1'h0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Control words; both brightness codes live in word zero
  always_ff @(posedge ref_clk) begin
    if (srst)
      ctrl0_r <= `CTRL0_RST;
    else if (wr_pend_r && wr_addr_r == `OFS_CTRL0)
      ctrl0_r <= hwdata[6:0]; // R9
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      ctrl1_r <= `CTRL1_RST;
    else if (wr_pend_r && wr_addr_r == `OFS_CTRL1)
      ctrl1_r <= hwdata[6:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      osc_sel_r <= `OSC_SEL_RST;
    else if (wr_pend_r && wr_addr_r == `OFS_OSC_SEL)
      osc_sel_r <= hwdata[0]; // R10
  end

  // Dot rows: one word per row, bits 19..0 are columns 19..0.
  // Sleep does not touch them, so the picture survives it.
  for (genvar r = 0; r < 8; r++) begin : g_dot
    always_ff @(posedge ref_clk) begin
      if (srst)
        dot_r[r] <= `DOT_RST;
      else if (wr_pend_r && wr_addr_r == (`OFS_DOT_BASE + 8'(4 * r)))
        dot_r[r] <= hwdata[19:0]; // R1 R14
    end
  end

  // Read data is prepared in the address phase
  always_comb begin
    rd_nxt = 32'h00000000;
    if (haddr[7:0] == `OFS_CTRL0)
      rd_nxt[6:0] = ctrl0_r;
    else if (haddr[7:0] == `OFS_CTRL1)
      rd_nxt[6:0] = ctrl1_r;
    else if (haddr[7:0] == `OFS_OSC_SEL)
      rd_nxt[0] = osc_sel_r;
    else if (haddr[7:0] == `OFS_STATUS) begin
      rd_nxt[`ST_CYC_LSB +: 6] = cyc;
      rd_nxt[`ST_ROW_LSB +: 3] = row;
      rd_nxt[`ST_RUN_BIT]      = run;
    end else if (haddr[7:0] >= `OFS_DOT_BASE &&
                 haddr[7:0] <= `OFS_DOT_LAST && haddr[1:0] == 2'h0)
      rd_nxt[19:0] = dot_r[haddr[4:2]];
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite)
      hrdata <= rd_nxt;
  end

  // Display clock and scan counters
  assign run = ctrl0_r[`CW0_RUN_BIT];

  display_tick_gen #(
    .INT_DIV (INT_DIV)
  ) u_tick (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .ext_osc  (ext_osc),
    .use_ext  (osc_sel_r),
    .prescale (ctrl1_r[`CW1_PRESC_BIT]),
    .osc_run  (run),
    .tick     (tick)
  );

  row_slot_counter u_cnt (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .cnt     (cnt)
  );

  assign row = cnt[8:6];
  assign cyc = cnt[5:0];

  // Lit cycles per slot; code 15 uses the full 60 cycles after blanking
  function automatic scan_pkg::on_cyc_t pwm_cycles(input logic [3:0] code);
    unique case (code)
      4'h0: pwm_cycles = 7'h00;
      4'h1: pwm_cycles = 7'h01;
      4'h2: pwm_cycles = 7'h02;
      4'h3: pwm_cycles = 7'h03;
      4'h4: pwm_cycles = 7'h04;
      4'h5: pwm_cycles = 7'h05;
      4'h6: pwm_cycles = 7'h06;
      4'h7: pwm_cycles = 7'h08;
      4'h8: pwm_cycles = 7'h0a;
      4'h9: pwm_cycles = 7'h0c;
      4'ha: pwm_cycles = 7'h0f;
      4'hb: pwm_cycles = 7'h13;
      4'hc: pwm_cycles = 7'h19;
      4'hd: pwm_cycles = 7'h24;
      4'he: pwm_cycles = 7'h30;
      4'hf: pwm_cycles = 7'h3c;
    endcase
  endfunction

  assign on_cyc = pwm_cycles(ctrl0_r[`CW0_PWM_LSB +: 4]); // R6 R7 R15

  // Lit window sits right behind the blanking cycles
  assign lit = run && ({1'b0, cyc} >= `BLANK_CYC) &&
               ({1'b0, cyc} < `BLANK_CYC + on_cyc); // R5 R17

  assign row_data = dot_r[row];

  always_ff @(posedge ref_clk) begin
    if (srst)
      row_en <= 8'h00;
    else if (!run)
      row_en <= 8'h00; // R14
    else
      row_en <= 8'h01 << row; // R2
  end

  // Columns and row select come from the same counter state
  always_ff @(posedge ref_clk) begin
    if (srst)
      col_on <= 20'h00000;
    else
      col_on <= lit ? row_data : 20'h00000; // R1 R11
  end

  always_ff @(posedge ref_clk) begin
    if (srst)
      col_current_pct <= `PEAK_PCT_00;
    else begin
      unique case (ctrl0_r[`CW0_PEAK_LSB +: 2]) // R15
        2'h0: col_current_pct <= `PEAK_PCT_00; // R8
        2'h1: col_current_pct <= `PEAK_PCT_01;
        2'h2: col_current_pct <= `PEAK_PCT_10;
        2'h3: col_current_pct <= `PEAK_PCT_11;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence slot_end_s;
    tick && cyc == `SLOT_LAST;
  endsequence

  sequence pass_end_s;
    tick && cnt == 9'h1ff;
  endsequence

  AST_ONE_ROW: assert property ($onehot0(row_en)) // R2
    else $error("More than one row enabled");

  AST_SLOT_ADVANCE: assert property ( // R4
    slot_end_s |=> row == 3'($past(row) + 3'h1))
    else $error("Row did not advance at slot end");

  AST_PASS_WRAP: assert property (pass_end_s |=> cnt == 9'h000) // R3
    else $error("Pass did not wrap to first slot");

  AST_BLANKING: assert property ( // R5
    ({1'b0, cyc} < `BLANK_CYC) |=> col_on == 20'h00000)
    else $error("Columns lit during blanking");

  AST_LIT_END: assert property ( // R17
    ({1'b0, cyc} >= `BLANK_CYC + on_cyc) |=> col_on == 20'h00000)
    else $error("Columns lit after on-time");

  AST_ROW_DATA: assert property ( // R11
    lit |=> col_on == $past(row_data) && row_en[$past(row)])
    else $error("Column data not from enabled row");

  AST_PWM_1101: assert property ( // R7
    ctrl0_r[3:0] == 4'hd |-> on_cyc == 7'h24)
    else $error("Code 1101 not sixty percent");

  AST_PEAK_00: assert property ( // R8
    ctrl0_r[5:4] == 2'h0 |=> col_current_pct == `PEAK_PCT_00)
    else $error("Peak code 00 not 73 percent");

  AST_SLEEP_OFF: assert property ( // R14
    !run |=> row_en == 8'h00 && col_on == 20'h00000)
    else $error("Drivers active in sleep");

  AST_RESET_CNT: assert property ( // R16
    @(posedge ref_clk) disable iff (1'b0) srst |=> cnt == 9'h000)
    else $error("Counter not cleared by reset");

  sequence ctrl0_wr_s;
    acc && hwrite && haddr[7:0] == `OFS_CTRL0 ##1 1'b1;
  endsequence

  AST_CTRL0_WRITE: assert property ( // R9
    ctrl0_wr_s |=> ctrl0_r == $past(hwdata[6:0]))
    else $error("Control word zero write lost");

  AST_SLEEP_HALT: assert property ( // R14
    !run && !osc_sel_r |-> ##2 $stable(cnt))
    else $error("Internal oscillator ran in sleep");

  AST_ROW_TRACK: assert property ( // R11
    run |=> $onehot(row_en) && row_en[$past(row)])
    else $error("Enabled row does not follow counter");

  // Lit ticks per slot, kept only so the on-time limit can be checked
  logic [6:0] lit_tally_r;

  always_ff @(posedge ref_clk) begin
    if (srst || (tick && cyc == `SLOT_LAST))
      lit_tally_r <= 7'h00;
    else if (tick && lit)
      lit_tally_r <= lit_tally_r + 7'h01;
  end

  AST_ON_LIMIT: assert property ( // R5
    slot_end_s |-> lit_tally_r <= `MAX_ON_CYC)
    else $error("Row lit longer than sixty cycles");

endmodule // led_matrix_refresh_scanner

`default_nettype wire

// [verilog/scan_defs.svh]
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH

// Register byte offsets
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_OSC_SEL    8'h08
`define OFS_STATUS     8'h0c
`define OFS_DOT_BASE   8'h20
`define OFS_DOT_LAST   8'h3c

// Control word 0 fields
`define CW0_PWM_LSB    0
`define CW0_PEAK_LSB   4
`define CW0_RUN_BIT    6
// Control word 1 fields
`define CW1_SERIAL_BIT 0
`define CW1_PRESC_BIT  1
// Status fields
`define ST_CYC_LSB     0
`define ST_ROW_LSB     6
`define ST_RUN_BIT     9

// Reset values
`define CTRL0_RST      7'h00
`define CTRL1_RST      7'h00
`define OSC_SEL_RST    1'h0
`define DOT_RST        20'h00000

// Scan timing; slot figures in display-clock cycles, prescaler in external clock rises, divider in ref_clk cycles
`define BLANK_CYC      7'h04
`define SLOT_LAST      6'h3f
`define PRESC_LAST     3'h7
`define INT_OSC_DIV    8
`define MAX_ON_CYC     7'h3c

// Peak current, percent of full scale
`define PEAK_PCT_00    7'h49
`define PEAK_PCT_01    7'h32
`define PEAK_PCT_10    7'h64
`define PEAK_PCT_11    7'h57

`endif

// [verilog/scan_pkg.sv]
`default_nettype none

package scan_pkg;
  typedef logic [19:0] col_vec_t;
  typedef logic [7:0]  row_vec_t;
  typedef logic [8:0]  scan_cnt_t;
  typedef logic [6:0]  ctrl_word_t;
  typedef logic [6:0]  on_cyc_t;
endpackage

`default_nettype wire

// [verilog/display_tick_gen.sv]
`include "scan_defs.svh"
`default_nettype none

module display_tick_gen #(
  parameter int unsigned INT_DIV = `INT_OSC_DIV
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ext_osc,
  input  wire logic use_ext,
  input  wire logic prescale,
  input  wire logic osc_run,
  output var  logic tick
);

  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       lvl_r;
  logic [2:0] presc_r;
  logic [7:0] div_r;
  logic       ext_rise;
  logic       int_tick;
  logic       ext_tick;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_r <= 1'h0;
      sync2_r <= 1'h0;
      sync3_r <= 1'h0;
    end else begin
      sync1_r <= ext_osc;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Level only moves once two stages agree, so a glitch makes no edge
  always_ff @(posedge ref_clk) begin
    if (srst)
      lvl_r <= 1'h0;
    else if (sync2_r == sync3_r)
      lvl_r <= sync3_r;
  end

  assign ext_rise = (sync2_r == sync3_r) && sync3_r && !lvl_r;

  always_ff @(posedge ref_clk) begin
    if (srst)
      presc_r <= 3'h0;
    else if (ext_rise && prescale)
      presc_r <= presc_r + 3'h1;
  end

  assign ext_tick = ext_rise && (!prescale || presc_r == `PRESC_LAST); // R13

  // Internal oscillator halts in sleep
  always_ff @(posedge ref_clk) begin
    if (srst || !osc_run)
      div_r <= 8'h00;
    else if (div_r == 8'(INT_DIV - 1))
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  assign int_tick = osc_run && (div_r == 8'(INT_DIV - 1)); // R14

  always_ff @(posedge ref_clk) begin
    if (srst)
      tick <= 1'h0;
    else
      tick <= use_ext ? ext_tick : int_tick; // R10
  end

endmodule // display_tick_gen

`default_nettype wire

// [verilog/row_slot_counter.sv]
`default_nettype none

module row_slot_counter (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               tick,
  output var  scan_pkg::scan_cnt_t cnt
);

  // Upper three bits are the row, lower six the cycle within the slot;
  // natural wrap of nine bits closes the pass after 512 ticks
  always_ff @(posedge ref_clk) begin
    if (srst)
      cnt <= '0; // R16
    else if (tick)
      cnt <= cnt + 9'h001; // R3 R4
  end

endmodule // row_slot_counter

`default_nettype wire

// [tb/led_sink_model.sv]
`default_nettype none

module led_sink_model (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  row_en,
  input  wire logic [19:0] col_on,
  output var  int          bad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two sinks at once would short rows; columns need a sink to light
  always @(posedge ref_clk) begin
    if (!srst && (!$onehot0(row_en) ||
                  (col_on != 0 && row_en == 0))) begin
      bad <= bad + 1;
    end
  end
endmodule // led_sink_model

`default_nettype wire

// [tb/led_matrix_refresh_scanner_tb_top.sv]
`default_nettype none

module led_matrix_refresh_scanner_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp, ext_osc, ext_en;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  logic [1:0]  htrans, ediv;
  logic [2:0]  hsize;
  logic [7:0]  row_en, prv;
  logic [19:0] col_on;
  logic [6:0]  col_current_pct;
  int miscompares, num_checks, bad, tpc, elit, skip, pv, cc, lit, first, pc;
  int dot_m[8];
  int pk[4] = '{73, 50, 100, 87};

  assign hready = hreadyout;
  always #20 ref_clk = ~ref_clk;

  led_matrix_refresh_scanner #(.INT_DIV(2)) i_dut (.ref_clk(ref_clk),
    .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_osc(ext_osc), .row_en(row_en), .col_on(col_on),
    .col_current_pct(col_current_pct));
  led_sink_model i_sink (.ref_clk(ref_clk), .srst(srst), .row_en(row_en),
    .col_on(col_on), .bad(bad));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 0, 32'(hresp));
  endtask

  // Arming off the sampling edge avoids racing the slot monitor
  task automatic arm(input int t, input int l);
    @(negedge ref_clk);
    tpc = t;
    elit = l;
    skip = 2;
    pv = 0;
    @(posedge ref_clk);
  endtask

  task wrap_up;
    miscompares += bad;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Slot model: lengths and lit span in ref_clk samples
  always @(posedge ref_clk) begin
    if (prv != 0 && row_en != 0 && row_en != prv) begin
      chk("row order", 32'({prv[6:0], prv[7]}), 32'(row_en));
      if (skip == 0) begin
        chk("slot len", 64 * tpc, cc);
        chk("lit len", elit * tpc, lit);
        chk("blank", 4 * tpc, first);
      end
      if (row_en == 8'h01) begin
        if (pv != 0) chk("pass len", 512 * tpc, pc);
        pv = (skip == 0);
        pc = 0;
      end
      if (skip > 0) skip--;
      cc = 0;
      lit = 0;
      first = -1;
    end
    if (col_on != 0) begin
      if (first < 0) first = cc;
      lit++;
      for (int r = 0; r < 8; r++)
        if (row_en[r]) chk("col data", dot_m[r], 32'(col_on));
    end
    cc++;
    pc++;
    prv = row_en;
  end

  always @(posedge ref_clk) begin
    if (ext_en) begin
      ediv <= ediv + 2'h1;
      if (ediv == 2'h3) ext_osc <= ~ext_osc;
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    wrap_up;
  end

  initial begin
    ref_clk = 0; srst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; ext_osc = 0; ext_en = 0; ediv = 0;
    seed = 32'h0dad; skip = 9; prv = 0; tpc = 2; elit = 36; first = -1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("row_en rst", 0, 32'(row_en));
    chk("col_on rst", 0, 32'(col_on));
    chk("pct rst", 32'h49, 32'(col_current_pct));
    bus(8'h0c, 1'b0, 0);
    chk("status rst", 0, q);
    for (int r = 0; r < 8; r++) begin
      dot_m[r] = (xs() & 32'hfffff) | 32'h1;
      bus(8'h20 + 8'(4 * r), 1'b1, dot_m[r]);
    end
    bus(8'h2c, 1'b0, 0);
    chk("dot read", dot_m[3], q);
    bus(8'h80, 1'b0, 0);
    chk("unmapped", 0, q);
    bus(8'h00, 1'b1, 32'h4d);
    bus(8'h00, 1'b0, 0);
    chk("ctrl0 read", 32'h4d, q);
    bus(8'h0c, 1'b0, 0);
    chk("status run", 32'h200, q & 32'h200);
    arm(2, 36);
    repeat (2600) @(posedge ref_clk);
    bus(8'h00, 1'b1, 32'h4f);
    arm(2, 60);
    repeat (1200) @(posedge ref_clk);
    arm(2, 36);
    for (int p = 3; p >= 0; p--) begin
      bus(8'h00, 1'b1, 32'h4d | (p << 4));
      repeat (3) @(posedge ref_clk);
      chk("peak pct", pk[p], 32'(col_current_pct));
    end
    repeat (600) @(posedge ref_clk);
    bus(8'h00, 1'b1, 32'h0d);
    repeat (4) @(posedge ref_clk);
    chk("sleep rows", 0, 32'(row_en));
    chk("sleep cols", 0, 32'(col_on));
    bus(8'h34, 1'b0, 0);
    chk("dot kept", dot_m[5], q);
    ext_en <= 1'b1;
    bus(8'h08, 1'b1, 32'h1);
    bus(8'h00, 1'b1, 32'h4d);
    arm(8, 36);
    repeat (1700) @(posedge ref_clk);
    bus(8'h04, 1'b1, 32'h2);
    bus(8'h04, 1'b0, 0);
    chk("ctrl1 read", 32'h2, q);
    arm(64, 36);
    repeat (16500) @(posedge ref_clk);
    wrap_up;
  end
endmodule // led_matrix_refresh_scanner_tb_top

`default_nettype wire
